// >>> rtl/cab_core.sv
// cab_core: sequencer for add, and, shift, bit test, branches and software break
`timescale 1ns/1ps
`include "cab_map.svh"
module cab_core (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // asynchronous reset, active low
  input wire logic [7:0] rdata_in, // read data for the address on addr_out
  input wire logic [7:0] index_x_in, // x index from the rest of the core
  input wire logic [7:0] index_y_in, // y index from the rest of the core
  output logic [15:0] addr_out, // bus address of this cycle
  output logic [7:0] wdata_out, // write data of this cycle
  output logic we_out, // write strobe for this cycle
  output logic sync_out, // high in an opcode fetch cycle
  output logic [7:0] acc_out, // accumulator
  output logic [7:0] status_out, // processor status byte
  output logic [7:0] stack_out // stack pointer
);
  import cab_pkg::*;

  cab_state_t state_q, state_d;
  cab_mode_t mode;
  cab_kind_t kind;
  logic [15:0] addr_q, addr_d, pc_q, pc_d, ea_q, ea_d, pc_inc, br_target, ea_fix;
  logic [7:0] wdata_q, wdata_d, a_q, a_d, p_q, p_d, s_q, s_d, op_q, op_d, tmp_q, tmp_d;
  logic [7:0] idx, s_dec, shl_src, shl_res, and_res;
  logic [8:0] sum9, idx_sum;
  logic we_q, we_d, sync_q, cross_q, cross_d, br_flag, br_cond, exec_rd, do_shift;

  // ****************************************************************
  // decode
  // ****************************************************************
  always_comb begin
    mode = md_impl;
    kind = kd_none;
    case (op_q)
      `CAB_OP_ADC_IMM: begin mode = md_imm; kind = kd_adc; end
      `CAB_OP_ADC_ZP: begin mode = md_zp; kind = kd_adc; end
      `CAB_OP_ADC_ZPX: begin mode = md_zpx; kind = kd_adc; end
      `CAB_OP_ADC_ABS: begin mode = md_abs; kind = kd_adc; end
      `CAB_OP_ADC_ABSX: begin mode = md_absx; kind = kd_adc; end
      `CAB_OP_ADC_ABSY: begin mode = md_absy; kind = kd_adc; end
      `CAB_OP_ADC_IZX: begin mode = md_izx; kind = kd_adc; end
      `CAB_OP_ADC_IZY: begin mode = md_izy; kind = kd_adc; end
      `CAB_OP_AND_IMM: begin mode = md_imm; kind = kd_and; end
      `CAB_OP_AND_ZP: begin mode = md_zp; kind = kd_and; end
      `CAB_OP_AND_ZPX: begin mode = md_zpx; kind = kd_and; end
      `CAB_OP_AND_ABS: begin mode = md_abs; kind = kd_and; end
      `CAB_OP_AND_ABSX: begin mode = md_absx; kind = kd_and; end
      `CAB_OP_AND_ABSY: begin mode = md_absy; kind = kd_and; end
      `CAB_OP_AND_IZX: begin mode = md_izx; kind = kd_and; end
      `CAB_OP_AND_IZY: begin mode = md_izy; kind = kd_and; end
      `CAB_OP_SHL_ACC: begin mode = md_acc; kind = kd_shl; end
      `CAB_OP_SHL_ZP: begin mode = md_zp; kind = kd_shl; end
      `CAB_OP_SHL_ZPX: begin mode = md_zpx; kind = kd_shl; end
      `CAB_OP_SHL_ABS: begin mode = md_abs; kind = kd_shl; end
      `CAB_OP_SHL_ABSX: begin mode = md_absx; kind = kd_shl; end
      `CAB_OP_BIT_ZP: begin mode = md_zp; kind = kd_bit; end
      `CAB_OP_BIT_ABS: begin mode = md_abs; kind = kd_bit; end
      `CAB_OP_BR_PLUS, `CAB_OP_BR_MINUS, `CAB_OP_BR_OVF_CLR, `CAB_OP_BR_OVF_SET,
      `CAB_OP_BR_CARRY_CLR, `CAB_OP_BR_CARRY_SET, `CAB_OP_BR_NOT_ZERO,
      `CAB_OP_BR_ZERO: begin mode = md_rel; kind = kd_branch; end
      `CAB_OP_SOFT_BREAK: begin mode = md_brk; kind = kd_break; end
      default: begin mode = md_impl; kind = kd_none; end
    endcase
  end

  // flag select: 00 negative, 01 overflow, 10 carry, 11 zero; sense bit is the taken value
  always_comb begin
    case (op_q[`CAB_BR_SEL_HI:`CAB_BR_SEL_LO])
      2'h0: br_flag = p_q[`CAB_P_N];
      2'h1: br_flag = p_q[`CAB_P_V];
      2'h2: br_flag = p_q[`CAB_P_C];
      default: br_flag = p_q[`CAB_P_Z];
    endcase
    br_cond = (br_flag == op_q[`CAB_BR_SENSE]);
  end

  // ****************************************************************
  // datapath terms
  // ****************************************************************
  always_comb begin
    case (mode)
      md_zpx, md_absx, md_izx: idx = index_x_in;
      md_absy, md_izy: idx = index_y_in;
      default: idx = 8'h00;
    endcase
  end

  assign pc_inc = pc_q + 16'h0001;
  assign s_dec = s_q - 8'h01;
  assign br_target = pc_q + {{8{tmp_q[7]}}, tmp_q};
  assign ea_fix = ea_q + {7'h00, cross_q, 8'h00};
  assign idx_sum = {1'b0, (state_q == st_ptr_lo) ? rdata_in : tmp_q} + {1'b0, idx};
  assign sum9 = {1'b0, a_q} + {1'b0, rdata_in} + {8'h00, p_q[`CAB_P_C]};
  assign and_res = a_q & rdata_in;
  assign shl_src = (state_q == st_mod) ? tmp_q : a_q;
  assign shl_res = {shl_src[6:0], 1'b0};
  assign exec_rd = (state_q == st_oper && mode == md_imm) ||
                   (state_q == st_read && kind != kd_shl);
  assign do_shift = (state_q == st_oper && mode == md_acc) || state_q == st_mod;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    pc_d = pc_q;
    ea_d = ea_q;
    wdata_d = wdata_q;
    we_d = 1'b0;
    a_d = a_q;
    p_d = p_q;
    s_d = s_q;
    op_d = op_q;
    tmp_d = tmp_q;
    cross_d = cross_q;
    case (state_q)
      st_vec_lo: begin
        tmp_d = rdata_in;
        addr_d = addr_q + 16'h0001;
        state_d = st_vec_hi;
      end
      st_vec_hi: begin
        pc_d = {rdata_in, tmp_q};
        addr_d = {rdata_in, tmp_q};
        state_d = st_fetch;
      end
      st_fetch: begin
        op_d = rdata_in;
        pc_d = pc_inc;
        addr_d = pc_inc;
        state_d = st_oper;
      end
      st_oper: begin
        tmp_d = rdata_in;
        ea_d = {8'h00, rdata_in};
        addr_d = {8'h00, rdata_in};
        pc_d = pc_inc;
        cross_d = 1'b0;
        case (mode)
          md_imm: begin
            addr_d = pc_inc;
            state_d = st_fetch;
          end
          md_zp: state_d = st_read;
          md_zpx, md_izx: state_d = st_index;
          md_izy: state_d = st_ptr_lo;
          md_abs, md_absx, md_absy: begin
            addr_d = pc_inc;
            state_d = st_addr_hi;
          end
          md_rel: begin
            addr_d = pc_inc;
            state_d = br_cond ? st_br_take : st_fetch;
          end
          md_brk: begin
            // pc points at the padding byte, so the return is pc plus one
            addr_d = {`CAB_STACK_PAGE, s_q};
            wdata_d = pc_inc[15:8];
            we_d = 1'b1;
            state_d = st_push_hi;
          end
          default: begin
            // accumulator shift and unknown opcodes are one byte, two cycles
            pc_d = pc_q;
            addr_d = pc_q;
            state_d = st_fetch;
          end
        endcase
      end
      st_index: begin
        ea_d = {8'h00, ea_q[7:0] + idx};
        addr_d = {8'h00, ea_q[7:0] + idx};
        state_d = (mode == md_izx) ? st_ptr_lo : st_read;
      end
      st_ptr_lo: begin
        // the x form was indexed before the pointer read, only the y form adds the index here
        tmp_d = (mode == md_izy) ? idx_sum[7:0] : rdata_in;
        cross_d = (mode == md_izy) && idx_sum[8];
        addr_d = {8'h00, ea_q[7:0] + 8'h01};
        state_d = st_ptr_hi;
      end
      st_ptr_hi: begin
        ea_d = {rdata_in, tmp_q};
        addr_d = {rdata_in, tmp_q};
        state_d = cross_q ? st_fix : st_read;
      end
      st_addr_hi: begin
        pc_d = pc_inc;
        ea_d = {rdata_in, idx_sum[7:0]};
        addr_d = {rdata_in, idx_sum[7:0]};
        cross_d = idx_sum[8];
        // the x-indexed absolute shift always spends the fix cycle, whether or not the index crosses a page
        if (idx_sum[8] || (kind == kd_shl && mode == md_absx)) begin
          state_d = st_fix;
        end else begin
          state_d = st_read;
        end
      end
      st_fix: begin
        ea_d = ea_fix;
        addr_d = ea_fix;
        state_d = st_read;
      end
      st_read: begin
        if (kind == kd_shl) begin
          tmp_d = rdata_in;
          wdata_d = rdata_in;
          we_d = 1'b1;
          addr_d = ea_q;
          state_d = st_mod;
        end else begin
          addr_d = pc_q;
          state_d = st_fetch;
        end
      end
      st_mod: begin
        wdata_d = shl_res;
        we_d = 1'b1;
        addr_d = ea_q;
        state_d = st_write;
      end
      st_write: begin
        addr_d = pc_q;
        state_d = st_fetch;
      end
      st_br_take: begin
        pc_d = br_target;
        if (br_target[15:8] == pc_q[15:8]) begin
          addr_d = br_target;
          state_d = st_fetch;
        end else begin
          addr_d = {pc_q[15:8], br_target[7:0]};
          state_d = st_br_fix;
        end
      end
      st_br_fix: begin
        addr_d = pc_q;
        state_d = st_fetch;
      end
      st_push_hi: begin
        s_d = s_dec;
        addr_d = {`CAB_STACK_PAGE, s_dec};
        wdata_d = pc_q[7:0];
        we_d = 1'b1;
        state_d = st_push_lo;
      end
      st_push_lo: begin
        s_d = s_dec;
        addr_d = {`CAB_STACK_PAGE, s_dec};
        wdata_d = p_q | `CAB_P_BREAK_MASK;
        we_d = 1'b1;
        state_d = st_push_p;
      end
      st_push_p: begin
        // interrupt-disable is set here and loaded set by reset, never consulted
        s_d = s_dec;
        p_d[`CAB_P_I] = 1'b1;
        addr_d = `CAB_BREAK_VEC;
        state_d = st_vec_lo;
      end
      default: begin
        addr_d = pc_q;
        state_d = st_fetch;
      end
    endcase
    if (exec_rd) begin
      case (kind)
        kd_adc: begin
          a_d = sum9[7:0];
          p_d[`CAB_P_C] = sum9[8];
          p_d[`CAB_P_V] = ~(a_q[7] ^ rdata_in[7]) & (a_q[7] ^ sum9[7]);
          p_d[`CAB_P_N] = sum9[7];
          p_d[`CAB_P_Z] = (sum9[7:0] == 8'h00);
        end
        kd_and: begin
          a_d = and_res;
          p_d[`CAB_P_N] = and_res[7];
          p_d[`CAB_P_Z] = (and_res == 8'h00);
        end
        kd_bit: begin
          p_d[`CAB_P_N] = rdata_in[7];
          p_d[`CAB_P_V] = rdata_in[6];
          p_d[`CAB_P_Z] = (and_res == 8'h00);
        end
        default: p_d = p_q;
      endcase
    end
    if (do_shift) begin
      if (state_q == st_oper) begin
        a_d = shl_res;
      end
      p_d[`CAB_P_C] = shl_src[7];
      p_d[`CAB_P_N] = shl_res[7];
      p_d[`CAB_P_Z] = (shl_res == 8'h00);
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_q <= `CAB_RESET_VEC;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      sync_q <= (state_d == st_fetch);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_q <= 8'h00;
      p_q <= `CAB_P_RESET;
      s_q <= `CAB_SP_RESET;
    end else begin
      a_q <= a_d;
      p_q <= p_d;
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= st_vec_lo;
      pc_q <= 16'h0000;
      ea_q <= 16'h0000;
      op_q <= 8'h00;
      tmp_q <= 8'h00;
      cross_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      ea_q <= ea_d;
      op_q <= op_d;
      tmp_q <= tmp_d;
      cross_q <= cross_d;
    end
  end

  assign addr_out = addr_q;
  assign wdata_out = wdata_q;
  assign we_out = we_q;
  assign sync_out = sync_q;
  assign acc_out = a_q;
  assign status_out = p_q;
  assign stack_out = s_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_adc_imm_sum: assert property (sync_q && rdata_in == `CAB_OP_ADC_IMM |-> ##2 sync_q &&
    a_q == 8'($past(a_q) + $past(rdata_in) + $past(p_q[`CAB_P_C])))
    else $error("add immediate result or length wrong");
  a_and_imm_res: assert property (sync_q && rdata_in == `CAB_OP_AND_IMM |-> ##2
    a_q == ($past(a_q) & $past(rdata_in)) && p_q[`CAB_P_Z] == (a_q == 8'h00))
    else $error("and immediate result wrong");
  a_shl_acc_op: assert property (sync_q && rdata_in == `CAB_OP_SHL_ACC |-> ##2 sync_q &&
    a_q == {$past(a_q[6:0]), 1'b0} && p_q[`CAB_P_C] == $past(a_q[7]))
    else $error("accumulator shift wrong");
  a_bit_zp_flags: assert property (sync_q && rdata_in == `CAB_OP_BIT_ZP |-> ##3 sync_q &&
    p_q[`CAB_P_N] == $past(rdata_in[7]) && p_q[`CAB_P_V] == $past(rdata_in[6]) &&
    a_q == $past(a_q, 2))
    else $error("bit test flags or length wrong");
  a_page_fix_cyc: assert property (state_q == st_addr_hi && kind != kd_shl && idx_sum[8]
    |=> !sync_q [*2] ##1 sync_q)
    else $error("page crossing cycle missing");
  a_branch_skip: assert property (state_q == st_oper && mode == md_rel && !br_cond
    |=> sync_q && addr_q == $past(pc_inc))
    else $error("untaken branch not two cycles");
  a_branch_far: assert property (state_q == st_br_take && br_target[15:8] != pc_q[15:8]
    |=> !sync_q ##1 sync_q && addr_q == $past(br_target, 2))
    else $error("far branch timing wrong");
  a_break_len: assert property (sync_q && rdata_in == `CAB_OP_SOFT_BREAK
    |=> !sync_q [*6] ##1 sync_q)
    else $error("break not seven cycles");
  a_break_push: assert property (sync_q && rdata_in == `CAB_OP_SOFT_BREAK
    |-> ##2 we_q [*3] ##1 !we_q && addr_q == `CAB_BREAK_VEC && p_q[`CAB_P_I])
    else $error("break push sequence wrong");
  a_break_unmask: assert property (sync_q && rdata_in == `CAB_OP_SOFT_BREAK &&
    p_q[`CAB_P_I] |-> ##2 we_q && addr_q[15:8] == `CAB_STACK_PAGE)
    else $error("break suppressed by interrupt-disable");

endmodule // cab_core

// >>> rtl/cab_map.svh
// address map, opcodes and status bit positions for the cab core
`ifndef CAB_MAP_SVH
`define CAB_MAP_SVH
`define CAB_RESET_VEC 16'hfffc
`define CAB_BREAK_VEC 16'hfffe
`define CAB_STACK_PAGE 8'h01
`define CAB_SP_RESET 8'hfd
`define CAB_P_RESET 8'h24
`define CAB_P_BREAK_MASK 8'h10
`define CAB_P_N 7
`define CAB_P_V 6
`define CAB_P_I 2
`define CAB_P_Z 1
`define CAB_P_C 0
`define CAB_BR_SEL_HI 7
`define CAB_BR_SEL_LO 6
`define CAB_BR_SENSE 5
`define CAB_OP_ADC_IMM 8'h69
`define CAB_OP_ADC_ZP 8'h65
`define CAB_OP_ADC_ZPX 8'h75
`define CAB_OP_ADC_ABS 8'h6d
`define CAB_OP_ADC_ABSX 8'h7d
`define CAB_OP_ADC_ABSY 8'h79
`define CAB_OP_ADC_IZX 8'h61
`define CAB_OP_ADC_IZY 8'h71
`define CAB_OP_AND_IMM 8'h29
`define CAB_OP_AND_ZP 8'h25
`define CAB_OP_AND_ZPX 8'h35
`define CAB_OP_AND_ABS 8'h2d
`define CAB_OP_AND_ABSX 8'h3d
`define CAB_OP_AND_ABSY 8'h39
`define CAB_OP_AND_IZX 8'h21
`define CAB_OP_AND_IZY 8'h31
`define CAB_OP_SHL_ACC 8'h0a
`define CAB_OP_SHL_ZP 8'h06
`define CAB_OP_SHL_ZPX 8'h16
`define CAB_OP_SHL_ABS 8'h0e
`define CAB_OP_SHL_ABSX 8'h1e
`define CAB_OP_BIT_ZP 8'h24
`define CAB_OP_BIT_ABS 8'h2c
`define CAB_OP_BR_PLUS 8'h10
`define CAB_OP_BR_MINUS 8'h30
`define CAB_OP_BR_OVF_CLR 8'h50
`define CAB_OP_BR_OVF_SET 8'h70
`define CAB_OP_BR_CARRY_CLR 8'h90
`define CAB_OP_BR_CARRY_SET 8'hb0
`define CAB_OP_BR_NOT_ZERO 8'hd0
`define CAB_OP_BR_ZERO 8'hf0
`define CAB_OP_SOFT_BREAK 8'h00
`endif

// >>> rtl/cab_pkg.sv
// types shared by the cab core
package cab_pkg;
  typedef enum logic [4:0] {
    st_vec_lo, st_vec_hi, st_fetch, st_oper, st_addr_hi, st_index, st_ptr_lo, st_ptr_hi,
    st_fix, st_read, st_mod, st_write, st_br_take, st_br_fix, st_push_hi, st_push_lo,
    st_push_p
  } cab_state_t;
  typedef enum logic [3:0] {
    md_imm, md_zp, md_zpx, md_abs, md_absx, md_absy, md_izx, md_izy, md_acc, md_rel,
    md_brk, md_impl
  } cab_mode_t;
  typedef enum logic [2:0] {
    kd_adc, kd_and, kd_shl, kd_bit, kd_branch, kd_break, kd_none
  } cab_kind_t;
endpackage

// >>> tb/cab_mem_model.sv
// combinational program and data memory model facing the cab core bus
`timescale 1ns/1ps
module cab_mem_model (
  input wire logic clk_in, // bus clock
  input wire logic [15:0] addr_in, // address from the core
  input wire logic [7:0] wdata_in, // write data from the core
  input wire logic we_in, // write strobe, one cycle per write
  output logic [7:0] rdata_out // read data in the same cycle as the address
);
  logic [7:0] mem [0:65535];

  // ****************************************
  // storage
  // ****************************************
  // unused space holds an opcode the core treats as a no-op, so a stray fetch stays defined
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hea;
    end
  end

  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  // no wait states: the core samples this at the edge that ends the cycle
  assign rdata_out = mem[addr_in];
endmodule // cab_mem_model

// >>> tb/cab_core_tb_top.sv
// self-checking bench for the cab core: add, and, shift, bit test, branches, break
`timescale 1ns/1ps
`define CAB_CHECK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module cab_core_tb_top;
  logic clk_in;
  logic rst_n_in;
  logic [7:0] bus_rdata;
  logic [7:0] index_x_in;
  logic [7:0] index_y_in;
  logic [7:0] x_val;
  logic [7:0] y_val;
  logic [15:0] addr_out;
  logic [7:0] wdata_out;
  logic we_out;
  logic sync_out;
  logic [7:0] acc_out;
  logic [7:0] status_out;
  logic [7:0] stack_out;
  logic [15:0] pc;
  int cyc;
  int n_mismatch;
  int n_checks;

  cab_core dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .rdata_in(bus_rdata),
    .index_x_in(index_x_in), .index_y_in(index_y_in), .addr_out(addr_out),
    .wdata_out(wdata_out), .we_out(we_out), .sync_out(sync_out), .acc_out(acc_out),
    .status_out(status_out), .stack_out(stack_out));

  cab_mem_model mem_model (.clk_in(clk_in), .addr_in(addr_out), .wdata_in(wdata_out),
    .we_in(we_out), .rdata_out(bus_rdata));

  // ****************************************
  // clock, index drivers, watchdog
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    index_x_in <= x_val;
    index_y_in <= y_val;
  end

  // the whole run needs about 170 cycles, so this only trips on a hang
  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    $display("wrong value at %0t: watchdog ran out", $time);
    test_done();
  end

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // instruction drivers
  // ****************************************
  // code is placed while the core sits in the fetch cycle of pc, before the opcode is sampled
  task automatic step(input logic [7:0] b0, b1, b2, input int n);
    int k;
    mem_model.mem[pc] = b0;
    if (n > 1) begin
      mem_model.mem[pc + 16'd1] = b1;
    end
    if (n > 2) begin
      mem_model.mem[pc + 16'd2] = b2;
    end
    k = 0;
    while (!(sync_out === 1'b1 && addr_out === pc) && k < 100) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    if (k >= 100) begin
      n_mismatch++;
      $display("wrong value at %0t: fetch of the next opcode never came", $time);
    end
    cyc = 0;
    do begin
      @(posedge clk_in);
      #1;
      cyc++;
    end while (sync_out !== 1'b1 && cyc < 20);
  endtask

  task automatic op(input logic [7:0] b0, b1, b2, input int n, input int ecyc,
      input logic [7:0] eacc, est);
    step(b0, b1, b2, n);
    pc = pc + 16'(n);
    `CAB_CHECK(cyc, ecyc)
    `CAB_CHECK(addr_out, pc)
    `CAB_CHECK(acc_out, eacc)
    `CAB_CHECK(status_out, est)
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_add;
    mem_model.mem[16'h0010] = 8'h80;
    mem_model.mem[16'h1234] = 8'hff;
    op(8'h69, 8'h7f, 8'h00, 2, 2, 8'h7f, 8'h24);
    op(8'h69, 8'h01, 8'h00, 2, 2, 8'h80, 8'he4);
    op(8'h65, 8'h10, 8'h00, 2, 3, 8'h00, 8'h67);
    op(8'h6d, 8'h34, 8'h12, 3, 4, 8'h00, 8'h27);
    $display("test add done");
  endtask

  task automatic t_and;
    mem_model.mem[16'h1240] = 8'h10;
    mem_model.mem[16'h0011] = 8'h0f;
    op(8'h69, 8'hf0, 8'h00, 2, 2, 8'hf1, 8'ha4);
    op(8'h29, 8'h3c, 8'h00, 2, 2, 8'h30, 8'h24);
    op(8'h2d, 8'h40, 8'h12, 3, 4, 8'h10, 8'h24);
    op(8'h25, 8'h11, 8'h00, 2, 3, 8'h00, 8'h26);
    $display("test and done");
  endtask

  task automatic t_page;
    mem_model.mem[16'h12f5] = 8'h11;
    mem_model.mem[16'h1310] = 8'h22;
    mem_model.mem[16'h0020] = 8'hf8;
    mem_model.mem[16'h0021] = 8'h13;
    mem_model.mem[16'h1408] = 8'h0f;
    mem_model.mem[16'h13fc] = 8'h01;
    x_val = 8'h05;
    op(8'h7d, 8'hf0, 8'h12, 3, 4, 8'h11, 8'h24);
    x_val = 8'h20;
    op(8'h7d, 8'hf0, 8'h12, 3, 5, 8'h33, 8'h24);
    y_val = 8'h10;
    op(8'h31, 8'h20, 8'h00, 2, 6, 8'h03, 8'h24);
    y_val = 8'h04;
    op(8'h71, 8'h20, 8'h00, 2, 5, 8'h04, 8'h24);
    // zero page indexing wraps inside page zero; the x pointer form has no page penalty
    mem_model.mem[16'h0008] = 8'h0c;
    mem_model.mem[16'h0f80] = 8'h10;
    mem_model.mem[16'h1302] = 8'h0c;
    op(8'h35, 8'he8, 8'h00, 2, 4, 8'h04, 8'h24);
    op(8'h61, 8'hf0, 8'h00, 2, 6, 8'h14, 8'h24);
    op(8'h39, 8'hfe, 8'h12, 3, 5, 8'h04, 8'h24);
    $display("test page crossing done");
  endtask

  task automatic t_shift;
    mem_model.mem[16'h1500] = 8'hc1;
    mem_model.mem[16'h1501] = 8'h80;
    op(8'h0a, 8'h00, 8'h00, 1, 2, 8'h08, 8'h24);
    op(8'h0e, 8'h00, 8'h15, 3, 6, 8'h08, 8'ha5);
    `CAB_CHECK(mem_model.mem[16'h1500], 8'h82)
    x_val = 8'h01;
    op(8'h1e, 8'h00, 8'h15, 3, 7, 8'h08, 8'h27);
    `CAB_CHECK(mem_model.mem[16'h1501], 8'h00)
    mem_model.mem[16'h0040] = 8'h81;
    mem_model.mem[16'h0041] = 8'hc0;
    op(8'h06, 8'h40, 8'h00, 2, 5, 8'h08, 8'h25);
    `CAB_CHECK(mem_model.mem[16'h0040], 8'h02)
    op(8'h16, 8'h40, 8'h00, 2, 6, 8'h08, 8'ha5);
    `CAB_CHECK(mem_model.mem[16'h0041], 8'h80)
    $display("test shift done");
  endtask

  task automatic t_bit;
    mem_model.mem[16'h0030] = 8'hc0;
    mem_model.mem[16'h1600] = 8'h0c;
    op(8'h24, 8'h30, 8'h00, 2, 3, 8'h08, 8'he7);
    op(8'h2c, 8'h00, 8'h16, 3, 4, 8'h08, 8'h25);
    $display("test bit done");
  endtask

  // odd entries branch when their flag is set, even ones when it is clear
  task automatic t_branch;
    logic [7:0] ops [8] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hb0, 8'hd0, 8'hf0};
    int fpos [8] = '{7, 7, 6, 6, 0, 0, 1, 1};
    logic [7:0] st;
    logic [7:0] off;
    logic [15:0] nxt;
    logic [15:0] tgt;
    logic tk;
    int ecyc;
    st = 8'h25;
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        op(8'h29, 8'h00, 8'h00, 2, 2, 8'h00, 8'h27);
        op(8'h0a, 8'h00, 8'h00, 1, 2, 8'h00, 8'h26);
        op(8'h24, 8'h30, 8'h00, 2, 3, 8'h00, 8'he6);
        st = 8'he6;
      end
      for (int i = 0; i < 8; i++) begin
        tk = (st[fpos[i]] == i[0]);
        nxt = pc + 16'd2;
        // second pass aims each taken branch into a neighbouring page
        off = 8'h00;
        if (s == 1) begin
          off = (nxt[7:0] < 8'h80) ? ~nxt[7:0] : 8'h00 - nxt[7:0];
        end
        tgt = tk ? nxt + {{8{off[7]}}, off} : nxt;
        ecyc = !tk ? 2 : ((tgt[15:8] == nxt[15:8]) ? 3 : 4);
        step(ops[i], off, 8'h00, 2);
        `CAB_CHECK(cyc, ecyc)
        `CAB_CHECK(addr_out, tgt)
        pc = tgt;
      end
    end
    $display("test branch done");
  endtask

  task automatic t_break;
    logic [15:0] ret;
    ret = pc + 16'd2;
    step(8'h00, 8'h00, 8'h00, 1);
    `CAB_CHECK(cyc, 7)
    `CAB_CHECK(addr_out, 16'h0800)
    `CAB_CHECK(stack_out, 8'hfa)
    `CAB_CHECK(mem_model.mem[16'h01fd], ret[15:8])
    `CAB_CHECK(mem_model.mem[16'h01fc], ret[7:0])
    `CAB_CHECK(mem_model.mem[16'h01fb], 8'hf6)
    pc = 16'h0800;
    op(8'h69, 8'h01, 8'h00, 2, 2, 8'h01, 8'h24);
    $display("test break done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n_in = 1'b0;
    x_val = 8'h00;
    y_val = 8'h00;
    n_mismatch = 0;
    n_checks = 0;
    pc = 16'h0200;
    repeat (11) @(posedge clk_in);
    #1;
    `CAB_CHECK(addr_out, 16'hfffc)
    `CAB_CHECK(we_out, 1'b0)
    `CAB_CHECK(acc_out, 8'h00)
    `CAB_CHECK(status_out, 8'h24)
    `CAB_CHECK(stack_out, 8'hfd)
    mem_model.mem[16'hfffc] = 8'h00;
    mem_model.mem[16'hfffd] = 8'h02;
    mem_model.mem[16'hfffe] = 8'h00;
    mem_model.mem[16'hffff] = 8'h08;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    $display("test reset done");
    t_add();
    t_and();
    t_page();
    t_shift();
    t_bit();
    t_branch();
    t_break();
    test_done();
  end
endmodule // cab_core_tb_top
